// *** design/mode_reg_bank.sv ***
// mode registers 14h..19h: invert mask, termination, timer, activate, repair
// assumes mr commands arrive already decoded and synchronous to mclk
`timescale 1ns/10ps
`include "mode_bank_consts.svh"
// Behaviour
// RULE1: invert bits 0..3 map to dq8..11, 4..7 to dq12..15; mask lane never.
// RULE2: termination value in bits 2:0, zero default, 111b reserved.
// RULE3: controller avoids odd resistor codes unless mode register 3 bit 0 set; the model drops codes 1, 3, 5 and 6 and sends 7.
// RULE4: bit 3 zero enables clock termination, one disables it.
// RULE5: bit 4 zero enables chip-select termination, one disables it.
// RULE6: bit 5 zero keeps command/address termination, one disables it.
// RULE7: bits 7:6 hold byte-mode termination disable field.
// RULE8: two copies per termination bit; write select picks accessed copy.
// RULE9: operating select picks active copy; inactive copy has no effect.
// RULE10: timer run code 1..4 stops after 16..64 clocks; zero is manual.
// RULE11: with run code zero, stop command halts the timer.
// RULE12: controller never issues stop while run code is nonzero.
// RULE13: activate count bits 2:0 report tested limit code.
// RULE14: bit 3 reports unlimited, then bits 2:0 read zero.
// RULE15: write-only bits 6:4 select targeted refresh bank.
// RULE16: write-only bit 7 enables targeted refresh, default off.
// RULE17: repair register reports one availability bit per bank.
// RULE18: controller starts repair only on banks reporting a resource.
// RULE19: six-bit address decode places registers at 14h..19h.
// RULE20: invert bit one inverts calibration pattern lane; default 55h.
// RULE21: start command clears oscillator count before timer runs.
// RULE22: reserved 15h ignores writes and reads back zero.
// RULE23: reset loads every write-only field default, both copies.
module mode_reg_bank #(
  parameter logic [2:0] MAC_CODE = 3'h0, // tested limit code
  parameter logic UNLIMITED_MAC = 1'b1, // no activate limit
  parameter logic [7:0] REPAIR_AVAIL = 8'hff // spare rows per bank
) (
  input wire logic mclk, // device clock, 40 MHz
  input wire logic rst, // async reset, active high
  input wire logic mrw_en, // mode register write pulse
  input wire logic mrr_en, // mode register read pulse
  input wire mode_bank_pkg::mr_addr_t mr_addr, // register address
  input wire mode_bank_pkg::mr_data_t mr_wdata, // write operand
  input wire logic mpc_en, // multi-purpose command pulse
  input wire logic [6:0] mpc_op, // multi-purpose operand
  input wire logic write_set_point_select, // set point for access
  input wire logic operating_set_point_select, // set point in use
  input wire logic [7:0] cal_pattern, // raw calibration byte
  output mode_bank_pkg::mr_data_t mr_rdata, // read answer
  output logic mr_rvalid, // read answer valid
  output logic [2:0] controller_termination_value, // controller_termination_value code
  output logic clock_termination_enable, // ck termination on
  output logic chip_select_termination_enable, // cs termination on
  output logic cmd_addr_termination_disable, // ca termination off
  output logic [1:0] byte_mode_termination_disable, // byte mode field
  output logic targeted_row_refresh_enable, // targeted_row_refresh_enable on
  output logic [2:0] targeted_row_refresh_bank, // trr bank
  output logic [7:0] upper_dq_pattern, // dq15..8 calibration data
  output logic upper_mask_inversion_lane, // mask lane, never inverted
  output logic osc_running, // interval timer active
  output logic [15:0] osc_count // oscillator count
);
  import mode_bank_pkg::*;
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    mr_data_t run_code;
    logic [3:0] trr;
    mr_data_t inv;
    mr_data_t rdata;
    logic rvalid;
    logic [2:0] term_val;
    logic clk_en;
    logic cs_en;
    logic ca_dis;
    logic [1:0] byte_dis;
    logic [7:0] pat;
    logic mask_lane;
    logic running;
    logic [15:0] count;
  } bank_s;
  bank_s s_reg;
  bank_s s_next;
  mr_data_t term_rd;
  mr_data_t term_op;
  logic term_wr;
  logic tim_running;
  logic [15:0] tim_count;
  logic osc_start;
  logic osc_stop;
  // ************************************************************
  // submodules
  // ************************************************************
  assign term_wr = mrw_en && (mr_addr == `ADDR_TERM_CTRL); // RULE19
  set_point_pair u_term (
    .mclk(mclk),
    .rst(rst),
    .wr_en(term_wr),
    .wr_data(mr_wdata),
    .wr_sel(write_set_point_select),
    .op_sel(operating_set_point_select), // RULE9
    .rd_data(term_rd),
    .op_data(term_op)
  );
  // stop is ignored while the limit latched at start is nonzero, so the timer self-stops
  assign osc_start = mpc_en && (mpc_op == `MPC_START_OSC); // RULE21
  assign osc_stop = mpc_en && (mpc_op == `MPC_STOP_OSC); // RULE11
  strobe_timer u_timer (
    .mclk(mclk),
    .rst(rst),
    .run_code(s_reg.run_code),
    .start(osc_start),
    .stop(osc_stop),
    .running(tim_running),
    .count(tim_count)
  );
  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    // writes; reserved 15h and read-only addresses fall through
    if (mrw_en) begin
      if (mr_addr == `ADDR_STROBE_RUN) begin
        s_next.run_code = mr_wdata; // RULE10
      end else if (mr_addr == `ADDR_ACT_LIMIT) begin
        s_next.trr = mr_wdata[7:4]; // RULE15 RULE16
      end else if (mr_addr == `ADDR_UPPER_INV) begin
        s_next.inv = mr_wdata; // RULE20
      end
    end
    // write-only bits 7:4 of 18h read back zero, not the stored value
    if (mrr_en) begin
      s_next.rvalid = 1'b1;
      if (mr_addr == `ADDR_RSVD_SLOT) begin
        s_next.rdata = 8'h00; // RULE22
      end else if (mr_addr == `ADDR_TERM_CTRL) begin
        s_next.rdata = term_rd; // RULE8
      end else if (mr_addr == `ADDR_STROBE_RUN) begin
        s_next.rdata = s_reg.run_code;
      end else if (mr_addr == `ADDR_ACT_LIMIT) begin
        s_next.rdata = {4'h0, UNLIMITED_MAC,
          UNLIMITED_MAC ? 3'h0 : MAC_CODE}; // RULE13 RULE14
      end else if (mr_addr == `ADDR_REPAIR) begin
        s_next.rdata = REPAIR_AVAIL; // RULE17
      end else begin
        s_next.rdata = 8'h00;
      end
    end
    // termination outputs follow only the operating copy
    s_next.term_val = term_op[`TERM_CTRL_VAL_MSB:0]; // RULE2
    s_next.clk_en = !term_op[`TERM_CLK_BIT]; // RULE4
    s_next.cs_en = !term_op[`TERM_CS_BIT]; // RULE5
    s_next.ca_dis = term_op[`TERM_CA_BIT]; // RULE6
    s_next.byte_dis = term_op[`TERM_BYTE_LSB +: 2]; // RULE7
    // bit n of the mask maps to dq(8+n); mask lane passes true
    s_next.pat = cal_pattern ^ s_reg.inv; // RULE1 RULE20
    s_next.mask_lane = cal_pattern[0]; // RULE1
    s_next.running = tim_running;
    s_next.count = tim_count;
  end
  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_reg <= '{run_code: `STROBE_RUN_RESET, trr: `TRR_RESET,
        inv: `UPPER_INV_RESET, rdata: 8'h00, rvalid: 1'b0,
        term_val: 3'h0, clk_en: 1'b1, cs_en: 1'b1, ca_dis: 1'b0,
        byte_dis: 2'h0, pat: 8'h00, mask_lane: 1'b0,
        running: 1'b0, count: 16'h0000}; // RULE23
    end else begin
      s_reg <= s_next;
    end
  end
  // ************************************************************
  // outputs
  // ************************************************************
  assign mr_rdata = s_reg.rdata;
  assign mr_rvalid = s_reg.rvalid;
  assign controller_termination_value = s_reg.term_val;
  assign clock_termination_enable = s_reg.clk_en;
  assign chip_select_termination_enable = s_reg.cs_en;
  assign cmd_addr_termination_disable = s_reg.ca_dis;
  assign byte_mode_termination_disable = s_reg.byte_dis;
  assign targeted_row_refresh_enable = s_reg.trr[3]; // RULE16
  assign targeted_row_refresh_bank = s_reg.trr[2:0]; // RULE15
  assign upper_dq_pattern = s_reg.pat;
  assign upper_mask_inversion_lane = s_reg.mask_lane;
  assign osc_running = s_reg.running;
  assign osc_count = s_reg.count;
endmodule

// *** design/mode_bank_consts.svh ***
// constants for the mode register bank: addresses, field positions, resets
// assumes inclusion by bare name from the modules
`ifndef MODE_BANK_CONSTS_SVH
`define MODE_BANK_CONSTS_SVH
// ************************************************************
// addresses
// ************************************************************
`define ADDR_RSVD_SLOT 6'h15
`define ADDR_TERM_CTRL 6'h16
`define ADDR_STROBE_RUN 6'h17
`define ADDR_ACT_LIMIT 6'h18
`define ADDR_REPAIR 6'h19
`define ADDR_UPPER_INV 6'h14
// ************************************************************
// field positions
// ************************************************************
`define TERM_CTRL_VAL_MSB 2
`define TERM_CLK_BIT 3
`define TERM_CS_BIT 4
`define TERM_CA_BIT 5
`define TERM_BYTE_LSB 6
`define TRR_BANK_LSB 4
`define TRR_EN_BIT 7
`define UNLIMITED_BIT 3
// ************************************************************
// reset values
// ************************************************************
`define TERM_CTRL_RESET 8'h00
`define STROBE_RUN_RESET 8'h00
`define TRR_RESET 4'h0
`define UPPER_INV_RESET 8'h55
// ************************************************************
// commands and timing
// ************************************************************
`define MPC_STOP_OSC 7'h4d
`define MPC_START_OSC 7'h4b
`define RUN_STEP_CLOCKS 16
`define RUN_MAX_CODE 8'h04
`define RSVD_TERM_CODE 3'h7
`endif

// *** design/mode_bank_pkg.sv ***
// types shared by the mode register bank files
// assumes the constants header sits in the include path
package mode_bank_pkg;
  typedef logic [5:0] mr_addr_t;
  typedef logic [7:0] mr_data_t;
  typedef enum logic [2:0] {
    OSC_IDLE = 3'b001,
    OSC_RUN = 3'b010,
    OSC_DONE = 3'b100
  } osc_state_e;
endpackage

// *** design/set_point_pair.sv ***
// two copies of the termination register, one per frequency set point
// assumes write strobes come from logic on mclk
`timescale 1ns/10ps
`include "mode_bank_consts.svh"
module set_point_pair (
  input wire logic mclk, // device clock
  input wire logic rst, // async reset, active high
  input wire logic wr_en, // one-cycle write strobe
  input wire mode_bank_pkg::mr_data_t wr_data, // write value
  input wire logic wr_sel, // copy that writes and reads reach
  input wire logic op_sel, // copy that drives operation
  output mode_bank_pkg::mr_data_t rd_data, // selected copy
  output mode_bank_pkg::mr_data_t op_data // active copy
);
  import mode_bank_pkg::*;
  typedef struct packed {
    mr_data_t sp0;
    mr_data_t sp1;
  } pair_s;
  pair_s pair_reg;
  pair_s pair_next;
  // only the write-selected copy changes
  always_comb begin
    pair_next = pair_reg;
    if (wr_en && !wr_sel) begin
      pair_next.sp0 = wr_data; // RULE8
    end else if (wr_en && wr_sel) begin
      pair_next.sp1 = wr_data; // RULE8
    end
  end
  // both copies reset to defaults
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pair_reg <= {`TERM_CTRL_RESET, `TERM_CTRL_RESET}; // RULE23
    end else begin
      pair_reg <= pair_next;
    end
  end
  // inactive copy never reaches the termination outputs
  assign rd_data = wr_sel ? pair_reg.sp1 : pair_reg.sp0; // RULE8
  assign op_data = op_sel ? pair_reg.sp1 : pair_reg.sp0; // RULE9
endmodule

// *** design/strobe_timer.sv ***
// dqs interval timer with automatic or command stop
// assumes mpc strobes are one-cycle pulses on mclk
`timescale 1ns/10ps
`include "mode_bank_consts.svh"
module strobe_timer (
  input wire logic mclk, // device clock
  input wire logic rst, // async reset, active high
  input wire mode_bank_pkg::mr_data_t run_code, // run-time setting
  input wire logic start, // start oscillator pulse
  input wire logic stop, // stop oscillator pulse
  output logic running, // timer counting
  output logic [15:0] count // oscillator count result
);
  import mode_bank_pkg::*;
  typedef struct packed {
    osc_state_e st;
    logic [15:0] cnt;
    logic [7:0] limit;
  } tim_s;
  tim_s t_reg;
  tim_s t_next;
  // limit in clocks; codes above four are treated as manual stop
  function automatic logic [7:0] run_limit(input mr_data_t c);
    if (c != 8'h00 && c <= `RUN_MAX_CODE) begin
      run_limit = 8'(c * `RUN_STEP_CLOCKS);
    end else begin
      run_limit = 8'h00;
    end
  endfunction
  always_comb begin
    t_next = t_reg;
    case (t_reg.st)
      OSC_IDLE, OSC_DONE: begin
        if (start) begin
          t_next.cnt = 16'h0000; // RULE21
          t_next.limit = run_limit(run_code); // RULE10
          t_next.st = OSC_RUN;
        end
      end
      OSC_RUN: begin
        t_next.cnt = t_reg.cnt + 16'h0001;
        if (start) begin
          t_next.cnt = 16'h0000; // RULE21
          t_next.limit = run_limit(run_code);
        end else if (t_reg.limit == 8'h00 && stop) begin
          t_next.st = OSC_DONE; // RULE11
        end else if (t_reg.limit != 8'h00 &&
                     t_reg.cnt[7:0] == 8'(t_reg.limit - 8'h01)) begin
          t_next.st = OSC_DONE; // RULE10
        end
      end
      default: t_next.st = OSC_IDLE;
    endcase
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      t_reg <= '{st: OSC_IDLE, cnt: 16'h0000, limit: 8'h00};
    end else begin
      t_reg <= t_next;
    end
  end
  assign running = (t_reg.st == OSC_RUN);
  assign count = t_reg.cnt;
endmodule

// *** tb/mode_reg_bank_chk.sv ***
// concurrent checks on the mode register bank top ports
// assumes a bind onto every mode_reg_bank instance
`timescale 1ns/10ps
module mode_reg_bank_chk #(
  parameter logic [7:0] REPAIR_AVAIL = 8'hff // spare rows per bank
) (
  input wire logic mclk, // clock
  input wire logic rst, // reset
  input wire logic mrw_en, // write
  input wire logic mrr_en, // read
  input wire mode_bank_pkg::mr_addr_t mr_addr, // address
  input wire mode_bank_pkg::mr_data_t mr_wdata, // operand
  input wire logic mpc_en, // mpc
  input wire logic [6:0] mpc_op, // mpc operand
  input wire logic write_set_point_select, // access copy
  input wire logic operating_set_point_select, // active copy
  input wire logic [7:0] cal_pattern, // raw pattern
  input wire mode_bank_pkg::mr_data_t mr_rdata, // read data
  input wire logic mr_rvalid, // read valid
  input wire logic [2:0] controller_termination_value, // value
  input wire logic clock_termination_enable, // ck
  input wire logic chip_select_termination_enable, // cs
  input wire logic cmd_addr_termination_disable, // ca
  input wire logic [1:0] byte_mode_termination_disable, // byte
  input wire logic targeted_row_refresh_enable, // trr on
  input wire logic [2:0] targeted_row_refresh_bank, // trr bank
  input wire logic [7:0] upper_dq_pattern, // dq15..8
  input wire logic upper_mask_inversion_lane, // mask lane
  input wire logic osc_running, // timer on
  input wire logic [15:0] osc_count // count
);
  import mode_bank_pkg::*;
  mr_data_t c0, c1, inv, run, act;
  // ************************************************************
  // shadow registers, so outputs are judged against what was written
  // ************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      c0 <= 8'h00;
      c1 <= 8'h00;
      inv <= 8'h55;
      run <= 8'h00;
    end else if (mrw_en) begin
      if (mr_addr == 6'h16 && !write_set_point_select) c0 <= mr_wdata;
      if (mr_addr == 6'h16 && write_set_point_select) c1 <= mr_wdata;
      if (mr_addr == 6'h14) inv <= mr_wdata;
      if (mr_addr == 6'h17) run <= mr_wdata;
    end
  end
  // copy that drives the termination outputs
  assign act = operating_set_point_select ? c1 : c0;
  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  chk_read_valid: assert property (mrr_en |=> mr_rvalid)
    else $error("read answer missing");
  chk_valid_cause: assert property (mr_rvalid |-> $past(mrr_en))
    else $error("read valid without read");
  chk_rsvd_zero: assert property (
    mrr_en && mr_addr == 6'h15 |=> mr_rdata == 8'h00)
    else $error("reserved read not zero");
  chk_repair_read: assert property (
    mrr_en && mr_addr == 6'h19 |=> mr_rdata == REPAIR_AVAIL)
    else $error("repair status wrong");
  chk_mask_true: assert property (
    !$past(rst) |-> upper_mask_inversion_lane == $past(cal_pattern[0]))
    else $error("mask lane altered");
  chk_lane_invert: assert property (!$past(rst) |->
    upper_dq_pattern == ($past(cal_pattern) ^ $past(inv)))
    else $error("pattern inversion wrong");
  chk_term_active: assert property (
    !$past(rst) |->
    {byte_mode_termination_disable, cmd_addr_termination_disable,
     !chip_select_termination_enable, !clock_termination_enable,
     controller_termination_value} == $past(act))
    else $error("termination outputs wrong");
  chk_trr_write: assert property (
    mrw_en && mr_addr == 6'h18 |=> {targeted_row_refresh_enable,
    targeted_row_refresh_bank} == $past(mr_wdata[7:4]))
    else $error("row refresh fields wrong");
  chk_auto_stop: assert property (
    mpc_en && mpc_op == 7'h4b && run == 8'h01 |->
    ##2 osc_running ##[14:18] !osc_running)
    else $error("timer auto stop wrong");
  chk_manual_stop: assert property (
    mpc_en && mpc_op == 7'h4d && run == 8'h00 && osc_running |->
    ##[1:3] !osc_running)
    else $error("timer did not stop");
  cover property (mrr_en && mr_addr == 6'h19);
  cover property (mrw_en && mr_addr == 6'h16 && write_set_point_select);
  cover property (mpc_en && mpc_op == 7'h4d && osc_running);
endmodule
bind mode_reg_bank mode_reg_bank_chk #(.REPAIR_AVAIL(REPAIR_AVAIL)) chk_i (.*);

// *** tb/mr_cmd_model.sv ***
// memory controller model issuing mode register and mpc commands
// assumes the bench calls its tasks; one command in flight at a time
`timescale 1ns/10ps
module mr_cmd_model (
  input wire logic mclk, // device clock
  output logic mrw_en, // write pulse
  output logic mrr_en, // read pulse
  output logic [5:0] mr_addr, // address
  output logic [7:0] mr_wdata, // operand
  output logic mpc_en, // mpc pulse
  output logic [6:0] mpc_op, // mpc operand
  input wire logic [7:0] mr_rdata, // read data
  input wire logic mr_rvalid // read valid
);
  logic [7:0] run_code = 8'h00;
  initial {mrw_en, mrr_en, mpc_en, mr_addr, mr_wdata, mpc_op} = '0;
  // resistor codes 1, 3, 5 and 6 are never sent: mode register 3 bit 0 is low here
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    if (a == 6'h16 &&
        d[2:0] inside {3'h1, 3'h3, 3'h5, 3'h6}) return;
    if (a == 6'h17) run_code = d;
    @(posedge mclk) #1;
    {mrw_en, mr_addr, mr_wdata} = {1'b1, a, d};
    @(posedge mclk) #1;
    mrw_en = 1'b0;
    {mr_addr, mr_wdata} = ~{mr_addr, mr_wdata}; // released bus wanders
  endtask
  // read data is taken just after the edge that raised valid
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge mclk) #1;
    {mrr_en, mr_addr} = {1'b1, a};
    @(posedge mclk) #1;
    mrr_en = 1'b0;
    mr_addr = ~mr_addr;
    d = mr_rvalid ? mr_rdata : 8'hxx;
  endtask
  // stop is withheld while an automatic run time is set
  task automatic mpc(input logic [6:0] op);
    if (op == 7'h4d && run_code != 8'h00) return;
    @(posedge mclk) #1;
    {mpc_en, mpc_op} = {1'b1, op};
    @(posedge mclk) #1;
    mpc_en = 1'b0;
    mpc_op = ~mpc_op;
  endtask
  // repair is only started on a bank that reports a spare
  task automatic ppr_ok(input int b, output logic ok);
    logic [7:0] d;
    rd(6'h19, d);
    ok = d[b];
  endtask
endmodule

// *** tb/dram_mode_regs_odt_dqs_trr_tb_top.sv ***
// self-checking bench for the mode register bank
// assumes the controller model and the bound checker
`timescale 1ns/10ps
module dram_mode_regs_odt_dqs_trr_tb_top;
  logic mclk = 0, rst = 1, mrw_en, mrr_en, mpc_en, mr_rvalid, osc_running;
  logic write_set_point_select = 0, operating_set_point_select = 0;
  logic clock_termination_enable, chip_select_termination_enable;
  logic cmd_addr_termination_disable, targeted_row_refresh_enable;
  logic upper_mask_inversion_lane, ok;
  logic [1:0] byte_mode_termination_disable;
  logic [2:0] controller_termination_value, targeted_row_refresh_bank;
  logic [5:0] mr_addr;
  logic [6:0] mpc_op;
  logic [7:0] mr_wdata, mr_rdata, cal_pattern = 8'h3c, upper_dq_pattern, d;
  logic [15:0] osc_count;
  logic [7:0] term_bus;
  logic [3:0] trr_bus;
  // termination outputs gathered in register bit order
  assign term_bus = {byte_mode_termination_disable,
    cmd_addr_termination_disable, chip_select_termination_enable,
    clock_termination_enable, controller_termination_value};
  assign trr_bus = {targeted_row_refresh_enable, targeted_row_refresh_bank};
  int num_errors = 0, cmp_count = 0, n;
  mode_reg_bank dut (.*);
  mr_cmd_model ctl (.*);
  always #12.5 mclk = ~mclk;
  task automatic check(string s, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", s, e, g);
      num_errors++;
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // defaults after reset, status reads and pattern inversion
  task automatic test_reset;
    check("term", 8'h18, term_bus);
    check("trr", 4'h0, trr_bus);
    ctl.ppr_ok(7, ok);
    check("repair", 1, ok);
    ctl.wr(6'h15, 8'hff);
    ctl.rd(6'h15, d);
    check("rsvd", 0, d);
    ctl.rd(6'h3f, d);
    check("unmapped", 0, d);
    check("pattern", 8'h69, upper_dq_pattern);
    ctl.wr(6'h14, 8'h0f);
    cal_pattern = 8'hff;
    repeat (2) @(posedge mclk) #1;
    check("pattern", 8'hf0, upper_dq_pattern);
    check("mask", 1, upper_mask_inversion_lane);
    $display("test_reset done");
  endtask
  // set point copies and termination fields
  task automatic test_term;
    write_set_point_select = 1;
    ctl.wr(6'h16, 8'hea);
    repeat (3) @(posedge mclk) #1;
    check("inactive", 3'h0, controller_termination_value);
    operating_set_point_select = 1;
    repeat (3) @(posedge mclk) #1;
    check("fields", 8'hf2, term_bus);
    ctl.rd(6'h16, d);
    check("copy", 8'hea, d);
    // legal codes 0, 2, 4 and the reserved 7
    for (int i = 0; i < 4; i++) begin
      logic [2:0] v;
      v = 3'(2 * i + (i == 3));
      ctl.wr(6'h16, {5'h00, v});
      repeat (3) @(posedge mclk) #1;
      check("value", v, controller_termination_value);
    end
    $display("test_term done");
  endtask
  // row refresh bank sweep and read-only activate bits
  task automatic test_trr;
    for (int b = 0; b < 8; b++) begin
      ctl.wr(6'h18, {1'b1, 3'(b), 4'hf});
      check("trr", {1'b1, 3'(b)}, trr_bus);
    end
    ctl.rd(6'h18, d);
    check("activate", 8'h08, d);
    $display("test_trr done");
  endtask
  // automatic run times, then manual stop
  task automatic test_timer;
    for (int k = 1; k < 5; k++) begin
      ctl.wr(6'h17, 8'(k));
      ctl.mpc(7'h4b);
      n = 0;
      repeat (300) @(posedge mclk) #1 n += int'(osc_running === 1'b1);
      check("run", 16'(16 * k), 16'(n));
      check("count", 16'(16 * k), osc_count);
    end
    ctl.wr(6'h17, 8'h00);
    ctl.mpc(7'h4b);
    // the registered count shows the cleared value one edge later
    @(posedge mclk) #1;
    check("cleared", 16'h0000, osc_count);
    repeat (39) @(posedge mclk) #1;
    check("manual", 1, osc_running);
    ctl.mpc(7'h4d);
    repeat (3) @(posedge mclk) #1;
    check("stopped", 0, osc_running);
    $display("test_timer done");
  endtask
  // watchdog sized well above the roughly 1300 cycles of the tests
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge mclk) #1;
    rst = 0;
    repeat (2) @(posedge mclk) #1;
    test_reset();
    test_term();
    test_trr();
    test_timer();
    end_sim();
  end
endmodule
